// *** hdl/bcc_device.sv ***
// Processor end: sequences T-states and drives the shared cycle control pins.
// Assumes the partner end keeps hold request high until granted; the core side
// presents one cycle request at a time on cycReq/cycCode and waits for cycDone.
`timescale 1ns/1ns
// Behaviour
// - Direction pin high transmit, low receive
// - Hold floats direction and data enable high
// - Data enable low on every access
// - Read/ack enable mid T2 to mid T4
// - Write enable start T2 to mid T4
// - Requester holds request high until granted
// - Grant rises mid T4 or mid idle
// - Grant floats bus and control outputs
// - Request low drops the grant
// - Drive again only for next cycle
// - Partner synchronises hold request externally
// - Status valid during T4, T1, T2
// - Status passive in T3 or ready TW
// - Status leaving passive in T4 starts cycle
// - Return to passive ends the cycle
// - Status floats high during grant
// - Status codes 000 ack to 111 passive
// - Select valid T4 before to final T4
module bcc_device
  import bcc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Core side cycle request
  input wire logic cycReq,
  input wire logic [2:0] cycCode,
  output logic cycDone,
  output logic memSelect,
  // Shared pins
  bcc_if.device link
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic holdSync;
  logic modeSync;
  logic readySync;

  // Hold request is synchronised here too, on top of any external stage
  bcc_sync uHold (.core_clk(core_clk), .nrst(nrst), .asyncIn(link.holdReq), .syncOut(holdSync));
  bcc_sync uMode (.core_clk(core_clk), .nrst(nrst), .asyncIn(link.configSelect), .syncOut(modeSync));
  bcc_sync uRdy (.core_clk(core_clk), .nrst(nrst), .asyncIn(link.ready), .syncOut(readySync));

  // ----------------------------------------------------------------
  // T-state sequencer
  // ----------------------------------------------------------------
  bcc_state_t state_q, state_d;
  logic phase_q, phase_d;
  logic [2:0] code_q, code_d;
  logic busy_q, busy_d;
  logic grant_q, grant_d;
  logic done_q, done_d;
  logic sel_q, sel_d;
  // First pass of T4 is the lead-in before T1; second is the closing T4
  logic doneLatch_q, doneLatch_d;

  logic isWrite;
  logic isCycle;

  assign isWrite = code_q == BCC_ST_IO_WR || code_q == BCC_ST_MEM_WR;
  assign isCycle = code_q != BCC_ST_HALT && code_q != BCC_ST_PASSIVE;

  always_comb begin
    state_d = state_q;
    phase_d = ~phase_q;
    code_d = code_q;
    busy_d = busy_q;
    grant_d = grant_q;
    done_d = 1'b0;
    sel_d = sel_q;
    doneLatch_d = doneLatch_q;
    if (phase_q == BCC_PH_MID) begin
      case (state_q)
        BCC_TI: begin
          if (cycReq && !grant_q) begin
            // Idle moves on to the lead-in T4 before T1; status starts there
            state_d = BCC_T4;
            code_d = cycCode;
            busy_d = 1'b1;
            sel_d = cycCode[BCC_BIT_MEM];
          end
        end
        BCC_T1: state_d = BCC_T2;
        BCC_T2: state_d = BCC_T3;
        BCC_T3: state_d = readySync ? BCC_T4 : BCC_TW;
        BCC_TW: state_d = readySync ? BCC_T4 : BCC_TW;
        BCC_T4: begin
          // Lead-in T4 moves on to T1; closing T4 ends the cycle
          if (!doneLatch_q) begin
            state_d = BCC_T1;
            doneLatch_d = 1'b1;
          end else begin
            state_d = BCC_TI;
            busy_d = 1'b0;
            done_d = 1'b1;
            doneLatch_d = 1'b0;
          end
        end
        default: state_d = BCC_TI;
      endcase
      // Grant only at the middle of T4 or idle
      // A cycle starting in this idle wins; the grant waits for that cycle's closing T4
      if (!grant_q && holdSync && state_d == BCC_TI &&
          (state_q == BCC_TI || state_q == BCC_T4))
        grant_d = 1'b1;
      else if (grant_q && !holdSync)
        grant_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_q <= BCC_TI;
      phase_q <= BCC_PH_EARLY;
      code_q <= BCC_ST_PASSIVE;
      busy_q <= 1'b0;
      grant_q <= BCC_RST_GRANT;
      done_q <= 1'b0;
      sel_q <= BCC_RST_LEVEL_HIGH;
      doneLatch_q <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      code_q <= code_d;
      busy_q <= busy_d;
      grant_q <= grant_d;
      done_q <= done_d;
      sel_q <= sel_d;
      doneLatch_q <= doneLatch_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic [2:0] pinOut_q, pinOut_d;
  logic [2:0] pinOe_q, pinOe_d;
  logic statusActive;
  logic denActive;

  always_comb begin
    // Status live in lead-in T4, T1, T2; passive from T3 on
    statusActive = busy_q && (state_q == BCC_T1 || state_q == BCC_T2 ||
                   (state_q == BCC_T4 && doneLatch_q == 1'b0));
    // Read enables at mid T2, write at start of T2; both end at mid T4
    denActive = busy_q && isCycle && (
                (state_q == BCC_T2 && (isWrite || phase_q == BCC_PH_MID)) ||
                state_q == BCC_T3 || state_q == BCC_TW ||
                (state_q == BCC_T4 && doneLatch_q && phase_q == BCC_PH_EARLY));
    pinOut_d = {3{BCC_RST_LEVEL_HIGH}};
    pinOe_d = 3'h7;
    if (modeSync) begin
      pinOut_d[0] = ~denActive;
      pinOut_d[1] = busy_q ? code_q[BCC_BIT_XMIT] : BCC_RST_LEVEL_HIGH;
      pinOut_d[2] = sel_q;
    end else begin
      pinOut_d = statusActive ? code_q : BCC_ST_PASSIVE;
    end
    // Granted pins float in either mode
    if (grant_d) begin
      pinOe_d = 3'h0;
    end else if (pinOe_q == 3'h0 && !busy_d) begin
      // Stay off the bus after a hold until a cycle needs the pins again
      pinOe_d = 3'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pinOut_q <= BCC_ST_PASSIVE;
      pinOe_q <= 3'h0;
    end else begin
      pinOut_q <= pinOut_d;
      pinOe_q <= pinOe_d;
    end
  end

  assign link.pinOut = pinOut_q;
  assign link.pinOe = pinOe_q;
  assign link.busHoldGrant = grant_q;
  assign cycDone = done_q;
  assign memSelect = sel_q;
endmodule : bcc_device

// *** hdl/bcc_if.sv ***
// Interface joining the bus cycle controller and its outside party.
// Shared pins carry out, out-enable and in; the wire level is resolved here.
`timescale 1ns/1ns
interface bcc_if;
  // Shared pins, direction / data-enable / status
  logic [2:0] pinOut;
  logic [2:0] pinOe;
  logic [2:0] pinLevel;
  // Hold handshake, mode strap and ready
  logic holdReq;
  logic busHoldGrant;
  logic configSelect;
  logic ready;

  // Floated pins resolve to one through a pull-up
  assign pinLevel[0] = pinOe[0] ? pinOut[0] : 1'b1;
  assign pinLevel[1] = pinOe[1] ? pinOut[1] : 1'b1;
  assign pinLevel[2] = pinOe[2] ? pinOut[2] : 1'b1;

  modport device (
    output pinOut,
    output pinOe,
    output busHoldGrant,
    input holdReq,
    input configSelect,
    input ready
  );

  modport partner (
    input pinLevel,
    input busHoldGrant,
    output holdReq,
    output configSelect,
    output ready
  );
endinterface : bcc_if

// *** hdl/bcc_partner.sv ***
// Outside party: another bus master requesting hold, plus mode and ready drive.
// Assumes the device end resolves shared pins through the interface.
`timescale 1ns/1ns
module bcc_partner
  import bcc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // User side
  input wire logic wantBus,
  input wire logic maxMode,
  input wire logic memReady,
  output logic ownsBus,
  output logic [2:0] statusSeen,
  // Link
  bcc_if.partner link
);
  logic req_q, req_d;
  logic owns_q, owns_d;
  logic mode_q, mode_d;
  logic rdy_q, rdy_d;
  logic [2:0] st_q, st_d;
  logic grantSync;

  bcc_sync uGrant (.core_clk(core_clk), .nrst(nrst), .asyncIn(link.busHoldGrant), .syncOut(grantSync));

  always_comb begin
    req_d = req_q;
    // Keep request up until granted, then release when done
    if (wantBus)
      req_d = 1'b1;
    else if (grantSync || !req_q)
      req_d = 1'b0;
    owns_d = grantSync && req_q;
    mode_d = ~maxMode;
    rdy_d = memReady;
    // Leaving passive starts a cycle, returning ends it
    st_d = link.pinLevel;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      req_q <= 1'b0;
      owns_q <= 1'b0;
      mode_q <= 1'b1;
      rdy_q <= 1'b1;
      st_q <= BCC_ST_PASSIVE;
    end else begin
      req_q <= req_d;
      owns_q <= owns_d;
      mode_q <= mode_d;
      rdy_q <= rdy_d;
      st_q <= st_d;
    end
  end

  assign link.holdReq = req_q;
  assign link.configSelect = mode_q;
  assign link.ready = rdy_q;
  assign ownsBus = owns_q;
  assign statusSeen = st_q;
endmodule : bcc_partner

// *** hdl/bcc_pkg.sv ***
// Bus cycle control package: cycle kinds, status codes, timing state encodings.
// Assumes a single processor clock; one clock cycle stands for one half T-state.
package bcc_pkg;

  // ----------------------------------------------------------------
  // Cycle status codes, high bit first
  // ----------------------------------------------------------------
  localparam logic [2:0] BCC_ST_IRQ_ACK = 3'h0;
  localparam logic [2:0] BCC_ST_IO_RD = 3'h1;
  localparam logic [2:0] BCC_ST_IO_WR = 3'h2;
  localparam logic [2:0] BCC_ST_HALT = 3'h3;
  localparam logic [2:0] BCC_ST_CODE = 3'h4;
  localparam logic [2:0] BCC_ST_MEM_RD = 3'h5;
  localparam logic [2:0] BCC_ST_MEM_WR = 3'h6;
  localparam logic [2:0] BCC_ST_PASSIVE = 3'h7;

  // ----------------------------------------------------------------
  // Field positions inside a status code
  // ----------------------------------------------------------------
  localparam int BCC_BIT_MEM = 2;
  localparam int BCC_BIT_XMIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic BCC_RST_GRANT = 1'b0;
  localparam logic BCC_RST_LEVEL_HIGH = 1'b1;

  // Timing: each T-state is split into two clock phases, early and mid
  localparam logic BCC_PH_EARLY = 1'b0;
  localparam logic BCC_PH_MID = 1'b1;

  // Bus states, Gray coded along idle -> T1 -> T2 -> T3 -> TW -> T4
  typedef enum logic [2:0] {
    BCC_TI = 3'b000,
    BCC_T1 = 3'b001,
    BCC_T2 = 3'b011,
    BCC_T3 = 3'b010,
    BCC_TW = 3'b110,
    BCC_T4 = 3'b111,
    BCC_TH = 3'b101
  } bcc_state_t;

endpackage : bcc_pkg

// *** hdl/bcc_sync.sv ***
// Two flip-flop synchroniser for a single level.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/1ns
module bcc_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Level
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;
endmodule : bcc_sync

// *** sim/bcc_chk_sva.sv ***
// Checker for the shared cycle control pins and the hold handshake.
// Assumes the interface signals are wired to it by name.
`timescale 1ns/1ns
module bcc_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Link
  input wire logic [2:0] pinOe,
  input wire logic [2:0] pinLevel,
  input wire logic holdReq,
  input wire logic busHoldGrant,
  input wire logic configSelect,
  input wire logic ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // Hold handshake
  // ----------------------------------------------------------------
  property p_float;
    busHoldGrant && $past(busHoldGrant) |-> pinOe == 3'h0 && pinLevel == 3'h7;
  endproperty
  a_float: assert property (p_float) else $error("pins driven while granted");
  property p_rise;
    $rose(busHoldGrant) |-> holdReq;
  endproperty
  a_rise: assert property (p_rise) else $error("grant without request");
  property p_drop;
    $fell(holdReq) |-> ##[0:8] !busHoldGrant;
  endproperty
  a_drop: assert property (p_drop) else $error("grant kept after request low");
  property p_resume;
    $fell(busHoldGrant) |-> pinOe == 3'h0;
  endproperty
  a_resume: assert property (p_resume) else $error("pins driven at grant drop");
  // ----------------------------------------------------------------
  // Minimal mode strobes
  // ----------------------------------------------------------------
  property p_dir;
    configSelect && !pinLevel[0] && !$past(pinLevel[0]) |-> $stable(pinLevel[1]) && pinOe[1];
  endproperty
  a_dir: assert property (p_dir) else $error("direction moved under enable");
  property p_rd;
    configSelect && ready && $fell(pinLevel[0]) && !pinLevel[1] |-> !pinLevel[0] [*4] ##1 pinLevel[0];
  endproperty
  a_rd: assert property (p_rd) else $error("read enable length");
  property p_wr;
    configSelect && ready && $fell(pinLevel[0]) && pinLevel[1] |-> !pinLevel[0] [*5] ##1 pinLevel[0];
  endproperty
  a_wr: assert property (p_wr) else $error("write enable length");
  // ----------------------------------------------------------------
  // Maximal mode status
  // ----------------------------------------------------------------
  property p_stat;
    !configSelect && pinLevel != 3'h7 && $past(pinLevel) != 3'h7 |-> $stable(pinLevel);
  endproperty
  a_stat: assert property (p_stat) else $error("status changed mid cycle");
  property p_end;
    !configSelect && ready && $past(ready, 4) && pinLevel != 3'h7 && pinLevel != 3'h3
      |-> ##[1:8] pinLevel == 3'h7;
  endproperty
  a_end: assert property (p_end) else $error("status not passive");
endmodule : bcc_chk

// *** sim/testbench.sv ***
// Testbench: device and partner ends joined through the link interface.
// Assumes the design files under hdl/ are compiled first.
`timescale 1ns/1ns
module testbench
  import bcc_pkg::*;
;
  logic core_clk = 0, nrst = 0, cycReq = 0, wantBus = 0, maxMode = 0, memReady = 1;
  logic [2:0] cycCode = 3'h0, statusSeen, lastSt = 3'h7, minSeen = 3'h0;
  logic cycDone, memSelect, ownsBus;
  logic [2:0] notes[$];
  int err_count = 0, n_compared = 0;
  always #50 core_clk = ~core_clk;
  bcc_if link_if ();
  bcc_device i_bcc_device (.core_clk(core_clk), .nrst(nrst), .cycReq(cycReq),
    .cycCode(cycCode), .cycDone(cycDone), .memSelect(memSelect), .link(link_if));
  bcc_partner i_bcc_partner (.core_clk(core_clk), .nrst(nrst), .wantBus(wantBus),
    .maxMode(maxMode), .memReady(memReady), .ownsBus(ownsBus), .statusSeen(statusSeen),
    .link(link_if));
  bcc_chk i_bcc_chk (.core_clk(core_clk), .nrst(nrst), .pinOe(link_if.pinOe),
    .pinLevel(link_if.pinLevel), .holdReq(link_if.holdReq),
    .busHoldGrant(link_if.busHoldGrant), .configSelect(link_if.configSelect),
    .ready(link_if.ready));
  // ----------------------------------------------------------------
  // Checks and closing
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [2:0] e, input logic [2:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task stop_test;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task start_req(input logic [2:0] code);
    // Halt shows no enable, so nothing is captured in minimal mode
    notes.push_back(maxMode ? code : (code == BCC_ST_HALT ? 3'h0 :
      {code[BCC_BIT_MEM], code[BCC_BIT_XMIT], 1'b1}));
    cycCode = code;
    cycReq = 1'b1;
  endtask : start_req
  task wait_done;
    for (int i = 0; i < 300 && cycDone !== 1'b1; i++) @(negedge core_clk);
    if (cycDone !== 1'b1) begin
      err_count++;
      stop_test();
    end
    chk("memSelect", {2'h0, cycCode[BCC_BIT_MEM]}, {2'h0, memSelect});
    cycReq = 1'b0;
    @(negedge core_clk);
  endtask : wait_done
  task wait_own(input logic v);
    for (int i = 0; i < 60 && ownsBus !== v; i++) @(negedge core_clk);
    chk("ownsBus", {2'h0, v}, {2'h0, ownsBus});
    if (ownsBus !== v) stop_test();
  endtask : wait_own
  task run_reset(input logic m);
    nrst = 1'b0;
    maxMode = m;
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask : run_reset
  // ----------------------------------------------------------------
  // Monitor
  // ----------------------------------------------------------------
  always @(negedge core_clk) begin
    if (nrst && maxMode && statusSeen !== 3'h7) lastSt = statusSeen;
    if (nrst && !maxMode && statusSeen[0] === 1'b0) minSeen = {statusSeen[2:1], 1'b1};
    if (cycDone === 1'b1) begin
      chk("cycle", notes.pop_front(), maxMode ? lastSt : minSeen);
      lastSt = 3'h7;
      minSeen = 3'h0;
    end
  end
  initial begin
    void'($urandom(45));
    run_reset(1'b0);
    for (int c = 0; c < 7; c++) begin
      start_req(c[2:0]);
      wait_done();
    end
    repeat (4) begin
      start_req(3'($urandom_range(6, 0)));
      wait_done();
    end
    wantBus = 1'b1;
    wait_own(1'b1);
    chk("float", 3'h7, link_if.pinLevel);
    start_req(BCC_ST_MEM_WR);
    repeat (10) @(negedge core_clk);
    chk("parked", 3'h7, link_if.pinLevel);
    wantBus = 1'b0;
    wait_own(1'b0);
    wait_done();
    run_reset(1'b1);
    for (int c = 0; c < 7; c++) begin
      start_req(c[2:0]);
      memReady = 1'b0;
      repeat ($urandom_range(6, 1)) @(negedge core_clk);
      memReady = 1'b1;
      wait_done();
    end
    stop_test();
  end
endmodule : testbench
